// ==== hdl/nv_access_pkg.sv ====
/*
 * shared constants for the data eeprom access block: special function
 * register addresses, control and interrupt bit positions, timing counts.
 * assumes a cpu data bus that presents one byte address per access and
 * a 10 MHz system clock.
 */
package nv_access_pkg;

   // -----------------------------------------------------------------
   // store geometry
   // -----------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int DEPTH  = 64;

   // -----------------------------------------------------------------
   // special function register addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] IND1_ADDR    = 8'h02;
   localparam logic [7:0] PTR1_LO_ADDR = 8'h03;
   localparam logic [7:0] PTR1_HI_ADDR = 8'h04;
   localparam logic [7:0] IND2_ADDR    = 8'h05;
   localparam logic [7:0] PTR2_LO_ADDR = 8'h06;
   localparam logic [7:0] PTR2_HI_ADDR = 8'h07;
   localparam logic [7:0] LOC_ADDR     = 8'h1e;
   localparam logic [7:0] BYTE_ADDR    = 8'h1f;
   localparam logic [7:0] IRQ_ADDR     = 8'h20;
   localparam logic [7:0] CTRL_SECTOR  = 8'h01;
   localparam logic [7:0] CTRL_OFFSET  = 8'h40;

   // -----------------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------------
   localparam int PROG_PERMIT_BIT  = 3;
   localparam int PROG_GO_BIT      = 2;
   localparam int FETCH_PERMIT_BIT = 1;
   localparam int FETCH_GO_BIT     = 0;
   localparam int IRQ_MASK_BIT     = 0;
   localparam int IRQ_FLAG_BIT     = 1;
   localparam int MF_ON_BIT        = 2;
   localparam int MF_FLAG_BIT      = 3;
   localparam logic [7:0] PTR_RESET  = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 100;
   localparam int READ_TIME_NS   = 400;
   localparam int READ_CYC       = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_TICK_NS  = 31250;
   localparam int TICK_DIV_DEF   = TIMER_TICK_NS / CLK_PERIOD_NS;
   localparam int WRITE_TIME_US  = 2000;
   localparam int WRITE_TICKS_DEF = (WRITE_TIME_US * 1000) / TIMER_TICK_NS;
   localparam int CNT_W          = 16;
   localparam int RD_CNT_W       = 4;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } nv_state_type;

   // true when a pointer pair selects the control register
   function automatic logic is_ctrl(input logic [7:0] hi, input logic [7:0] lo);
      is_ctrl = (hi == CTRL_SECTOR) && (lo == CTRL_OFFSET);
   endfunction : is_ctrl

endpackage : nv_access_pkg

// ==== hdl/nv_store.sv ====
/*
 * 64 x 8 storage array with registered read data.
 * assumes one access per cycle from the access controller.
 */
`timescale 1ns/1ps
module nv_store
   import nv_access_pkg::*;
(
   input  wire logic              mclk_i,
   input  wire logic              rst_n_i,
   input  wire logic              we_i,
   input  wire logic              re_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   output logic      [DATA_W-1:0] rdata_o
);

   // -----------------------------------------------------------------
   // array: no reset, contents survive as in the real cell array
   // -----------------------------------------------------------------
   logic [DATA_W-1:0] cells [DEPTH];
   logic [DATA_W-1:0] rdata_q;

   always_ff @(posedge mclk_i) begin
      if (we_i) begin
         cells[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= BYTE_RESET;
      end else if (re_i) begin
         rdata_q <= cells[addr_i];
      end
   end

   assign rdata_o = rdata_q;

endmodule : nv_store

// ==== hdl/nv_write_timer.sv ====
/*
 * write cycle timer: a free running prescaler stands in for the slow
 * internal oscillator, a tick counter times the write.
 * assumes start_i only while no write is running.
 */
`timescale 1ns/1ps
module nv_write_timer
   import nv_access_pkg::*;
#(
   parameter int TICK_DIV = TICK_DIV_DEF,
   parameter int TICKS    = WRITE_TICKS_DEF
) (
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   input  wire logic start_i,
   output logic      done_o
);

   localparam logic [CNT_W-1:0] DIV_LAST  = CNT_W'(TICK_DIV - 1);
   localparam logic [CNT_W-1:0] TICK_LOAD = CNT_W'(TICKS);
   localparam logic [CNT_W-1:0] ONE       = 16'h0001;

   logic [CNT_W-1:0] pre_q, pre_d, rem_q, rem_d;
   logic             tick;

   // -----------------------------------------------------------------
   // prescaler free runs, so the end of a write lands at no fixed
   // distance from its start in system clocks
   // -----------------------------------------------------------------
   always_comb begin
      tick   = (pre_q == DIV_LAST);
      pre_d  = tick ? '0 : pre_q + ONE;
      rem_d  = rem_q;
      done_o = tick && (rem_q == ONE);
      if (start_i) begin
         rem_d = TICK_LOAD;
      end else if (tick && (rem_q != '0)) begin
         rem_d = rem_q - ONE;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_q <= '0;
         rem_q <= '0;
      end else begin
         pre_q <= pre_d;
         rem_q <= rem_d;
      end
   end

   chk_done_on_tick: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      done_o |-> tick)
      else $error("write done outside a timer tick");

endmodule : nv_write_timer

// ==== hdl/data_eeprom_access_ctrl.sv ====
/*
 * data eeprom access controller: location, byte and control registers,
 * the two memory pointers that reach the control register, the read and
 * write sequencing and the write-done interrupt flags.
 * assumes the cpu presents one special function register access per
 * cycle on sfr_addr_i and that indirect ports resolve through the
 * pointers held here; read data appears one cycle after sfr_rd_i.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - store holds 64 bytes, reached bytewise
// - control register only via pointer to sector 1, 40h
// - location register six bits, top bits zero
// - byte register full eight bit read write
// - control keeps four bits, cleared, top reads zero
// - program permit low blocks every write
// - program go starts write, cleared when done
// - program go ignored without program permit
// - fetch permit low blocks reads
// - fetch go reads location, cleared when done
// - fetch go ignored without fetch permit
// - read byte stays until next access
// - write timed by free running internal timer
// - reset clears permits and pointer high bytes
// - write end sets done and shared flags
// - vector needs all enables and free stack
// - service clears shared flag only
module data_eeprom_access_ctrl
   import nv_access_pkg::*;
#(
   parameter int WRITE_TICKS = WRITE_TICKS_DEF,
   parameter int TICK_DIV    = TICK_DIV_DEF
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic [7:0] sfr_wdata_i,
   input  wire logic       sfr_rd_i,
   output logic      [7:0] sfr_rdata_o,
   input  wire logic       global_irq_on_i,
   input  wire logic       stack_full_i,
   input  wire logic       irq_serviced_i,
   output logic            irq_vector_o,
   output logic            nv_busy_o
);

   localparam logic [RD_CNT_W-1:0] READ_LOAD = RD_CNT_W'(READ_CYC);
   localparam logic [RD_CNT_W-1:0] RD_ONE    = 4'h1;
   localparam int                  RD_MAX    = READ_CYC + 1;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic [7:0]        ptr1_lo_q, ptr1_lo_d, ptr1_hi_q, ptr1_hi_d;
   logic [7:0]        ptr2_lo_q, ptr2_lo_d, ptr2_hi_q, ptr2_hi_d;
   nv_state_type      state_q, state_d;
   logic [ADDR_W-1:0] loc_q, loc_d;
   logic [DATA_W-1:0] byte_q, byte_d;
   logic              prog_permit_q, prog_permit_d, prog_go_q, prog_go_d;
   logic              fetch_permit_q, fetch_permit_d, fetch_go_q, fetch_go_d;
   logic [RD_CNT_W-1:0] rd_cnt_q, rd_cnt_d;
   logic              nv_done_irq_mask_on_q, nv_done_irq_mask_on_d;
   logic              nv_done_irq_flag_q, nv_done_irq_flag_d;
   logic              mf_on_q, mf_on_d, mf_flag_q, mf_flag_d;
   logic [7:0]        rdata_q, rdata_d;

   logic              hit1, hit2, ctrl_wr, irq_wr;
   logic              mem_we, mem_re, timer_start, wr_done;
   logic [DATA_W-1:0] mem_rdata;
   logic [7:0]        ctrl_view, loc_view, irq_view;

   // -----------------------------------------------------------------
   // address decode
   // -----------------------------------------------------------------
   always_comb begin
      hit1    = (sfr_addr_i == IND1_ADDR) && is_ctrl(ptr1_hi_q, ptr1_lo_q);
      hit2    = (sfr_addr_i == IND2_ADDR) && is_ctrl(ptr2_hi_q, ptr2_lo_q);
      ctrl_wr = sfr_wr_i && (hit1 || hit2);
      irq_wr  = sfr_wr_i && (sfr_addr_i == IRQ_ADDR);
   end

   // -----------------------------------------------------------------
   // memory pointers
   // -----------------------------------------------------------------
   always_comb begin
      ptr1_lo_d = ptr1_lo_q;
      ptr1_hi_d = ptr1_hi_q;
      ptr2_lo_d = ptr2_lo_q;
      ptr2_hi_d = ptr2_hi_q;
      if (sfr_wr_i) begin
         case (sfr_addr_i)
            PTR1_LO_ADDR: ptr1_lo_d = sfr_wdata_i;
            PTR1_HI_ADDR: ptr1_hi_d = sfr_wdata_i;
            PTR2_LO_ADDR: ptr2_lo_d = sfr_wdata_i;
            PTR2_HI_ADDR: ptr2_hi_d = sfr_wdata_i;
            default: ;
         endcase
      end
   end

   // power-on leaves both pointers in sector 0, out of reach of control
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ptr1_lo_q <= PTR_RESET;
         ptr1_hi_q <= PTR_RESET;
         ptr2_lo_q <= PTR_RESET;
         ptr2_hi_q <= PTR_RESET;
      end else begin
         ptr1_lo_q <= ptr1_lo_d;
         ptr1_hi_q <= ptr1_hi_d;
         ptr2_lo_q <= ptr2_lo_d;
         ptr2_hi_q <= ptr2_hi_d;
      end
   end

   // -----------------------------------------------------------------
   // access sequencer
   // -----------------------------------------------------------------
   always_comb begin
      state_d        = state_q;
      loc_d          = loc_q;
      byte_d         = byte_q;
      prog_permit_d  = prog_permit_q;
      prog_go_d      = prog_go_q;
      fetch_permit_d = fetch_permit_q;
      fetch_go_d     = fetch_go_q;
      rd_cnt_d       = rd_cnt_q;
      mem_we         = 1'b0;
      mem_re         = 1'b0;
      timer_start    = 1'b0;
      if (sfr_wr_i && (sfr_addr_i == LOC_ADDR)) begin
         loc_d = sfr_wdata_i[ADDR_W-1:0];
      end
      if (sfr_wr_i && (sfr_addr_i == BYTE_ADDR)) begin
         byte_d = sfr_wdata_i;
      end
      if (ctrl_wr) begin
         prog_permit_d  = sfr_wdata_i[PROG_PERMIT_BIT];
         fetch_permit_d = sfr_wdata_i[FETCH_PERMIT_BIT];
      end
      case (state_q)
         ST_IDLE: begin
            // go bits only act against a permit that was already set;
            // a write wins if software breaks the one-go-at-a-time rule
            if (ctrl_wr && sfr_wdata_i[PROG_GO_BIT] && prog_permit_q) begin
               prog_go_d   = 1'b1;
               mem_we      = 1'b1;
               timer_start = 1'b1;
               state_d     = ST_WRITE;
            end else if (ctrl_wr && sfr_wdata_i[FETCH_GO_BIT] && fetch_permit_q) begin
               fetch_go_d = 1'b1;
               mem_re     = 1'b1;
               rd_cnt_d   = READ_LOAD;
               state_d    = ST_READ;
            end
         end
         ST_READ: begin
            if (rd_cnt_q == RD_ONE) begin
               fetch_go_d = 1'b0;
               state_d    = ST_IDLE;
               if (fetch_permit_q) begin
                  byte_d = mem_rdata;
               end
            end else begin
               rd_cnt_d = rd_cnt_q - RD_ONE;
            end
         end
         ST_WRITE: begin
            if (wr_done) begin
               prog_go_d = 1'b0;
               state_d   = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q        <= ST_IDLE;
         loc_q          <= '0;
         byte_q         <= BYTE_RESET;
         prog_permit_q  <= 1'b0;
         prog_go_q      <= 1'b0;
         fetch_permit_q <= 1'b0;
         fetch_go_q     <= 1'b0;
         rd_cnt_q       <= '0;
      end else begin
         state_q        <= state_d;
         loc_q          <= loc_d;
         byte_q         <= byte_d;
         prog_permit_q  <= prog_permit_d;
         prog_go_q      <= prog_go_d;
         fetch_permit_q <= fetch_permit_d;
         fetch_go_q     <= fetch_go_d;
         rd_cnt_q       <= rd_cnt_d;
      end
   end

   // -----------------------------------------------------------------
   // store and write timer
   // -----------------------------------------------------------------
   // the cell takes its data at the start; the timer only decides when
   // the cycle is reported finished, so location and byte may change
   nv_store u_store (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .we_i    (mem_we),
      .re_i    (mem_re),
      .addr_i  (loc_q),
      .wdata_i (byte_q),
      .rdata_o (mem_rdata)
   );

   nv_write_timer #(
      .TICK_DIV (TICK_DIV),
      .TICKS    (WRITE_TICKS)
   ) u_timer (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .start_i (timer_start),
      .done_o  (wr_done)
   );

   // -----------------------------------------------------------------
   // write-done interrupt flags
   // -----------------------------------------------------------------
   always_comb begin
      nv_done_irq_mask_on_d = nv_done_irq_mask_on_q;
      nv_done_irq_flag_d    = nv_done_irq_flag_q;
      mf_on_d               = mf_on_q;
      mf_flag_d             = mf_flag_q;
      if (irq_wr) begin
         nv_done_irq_mask_on_d = sfr_wdata_i[IRQ_MASK_BIT];
         nv_done_irq_flag_d    = sfr_wdata_i[IRQ_FLAG_BIT];
         mf_on_d               = sfr_wdata_i[MF_ON_BIT];
         mf_flag_d             = sfr_wdata_i[MF_FLAG_BIT];
      end
      if (irq_serviced_i) begin
         mf_flag_d = 1'b0;
      end
      // set wins over any clear in the same cycle
      if (wr_done) begin
         nv_done_irq_flag_d = 1'b1;
         mf_flag_d          = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nv_done_irq_mask_on_q <= 1'b0;
         nv_done_irq_flag_q    <= 1'b0;
         mf_on_q               <= 1'b0;
         mf_flag_q             <= 1'b0;
      end else begin
         nv_done_irq_mask_on_q <= nv_done_irq_mask_on_d;
         nv_done_irq_flag_q    <= nv_done_irq_flag_d;
         mf_on_q               <= mf_on_d;
         mf_flag_q             <= mf_flag_d;
      end
   end

   assign irq_vector_o = global_irq_on_i && nv_done_irq_mask_on_q && nv_done_irq_flag_q
                         && mf_on_q && mf_flag_q && !stack_full_i;
   assign nv_busy_o    = (state_q != ST_IDLE);

   // -----------------------------------------------------------------
   // register read port
   // -----------------------------------------------------------------
   always_comb begin
      ctrl_view = 8'({prog_permit_q, prog_go_q, fetch_permit_q, fetch_go_q});
      loc_view  = 8'(loc_q);
      irq_view  = 8'({mf_flag_q, mf_on_q, nv_done_irq_flag_q, nv_done_irq_mask_on_q});
      rdata_d   = rdata_q;
      if (sfr_rd_i) begin
         case (sfr_addr_i)
            LOC_ADDR:     rdata_d = loc_view;
            BYTE_ADDR:    rdata_d = byte_q;
            PTR1_LO_ADDR: rdata_d = ptr1_lo_q;
            PTR1_HI_ADDR: rdata_d = ptr1_hi_q;
            PTR2_LO_ADDR: rdata_d = ptr2_lo_q;
            PTR2_HI_ADDR: rdata_d = ptr2_hi_q;
            IRQ_ADDR:     rdata_d = irq_view;
            IND1_ADDR:    rdata_d = hit1 ? ctrl_view : '0;
            IND2_ADDR:    rdata_d = hit2 ? ctrl_view : '0;
            default:      rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign sfr_rdata_o = rdata_q;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence seq_write_go;
      (state_q == ST_IDLE) && ctrl_wr && sfr_wdata_i[PROG_GO_BIT] && prog_permit_q;
   endsequence

   sequence seq_read_go;
      (state_q == ST_IDLE) && ctrl_wr && !sfr_wdata_i[PROG_GO_BIT]
         && sfr_wdata_i[FETCH_GO_BIT] && fetch_permit_q;
   endsequence

   chk_loc_read_top: assert property (sfr_rd_i && (sfr_addr_i == LOC_ADDR)
      |=> sfr_rdata_o[7:ADDR_W] == '0)
      else $error("location read shows upper bits");

   chk_ctrl_read_top: assert property (sfr_rd_i && hit1
      |=> (sfr_rdata_o[7:4] == '0) && (sfr_rdata_o[PROG_GO_BIT] == $past(prog_go_q)))
      else $error("control read wrong");

   chk_write_permit: assert property (mem_we |-> prog_permit_q && (state_q == ST_IDLE))
      else $error("store written without permit");

   chk_write_start: assert property (seq_write_go
      |=> prog_go_q && (state_q == ST_WRITE) && nv_busy_o)
      else $error("write cycle did not start");

   chk_write_ignored: assert property ((state_q == ST_IDLE) && !prog_permit_q
      && ctrl_wr && sfr_wdata_i[PROG_GO_BIT] |=> !prog_go_q)
      else $error("program go taken without permit");

   chk_read_ignored: assert property ((state_q == ST_IDLE) && !fetch_permit_q
      && ctrl_wr && sfr_wdata_i[FETCH_GO_BIT] |=> !fetch_go_q)
      else $error("fetch go taken without permit");

   chk_read_ends: assert property (seq_read_go
      |=> fetch_go_q ##[1:RD_MAX] !fetch_go_q)
      else $error("read cycle did not end in time");

   chk_byte_holds: assert property ((state_q == ST_IDLE)
      && !(sfr_wr_i && (sfr_addr_i == BYTE_ADDR)) |=> $stable(byte_q))
      else $error("byte register changed without access");

   chk_done_flags: assert property (wr_done
      |=> nv_done_irq_flag_q && mf_flag_q && !prog_go_q)
      else $error("write end did not set flags");

   chk_vector_gate: assert property (irq_vector_o
      |-> global_irq_on_i && !stack_full_i && nv_done_irq_mask_on_q)
      else $error("vector raised while blocked");

   chk_service_keep: assert property (irq_serviced_i && !wr_done && !irq_wr
      |=> !mf_flag_q && (nv_done_irq_flag_q == $past(nv_done_irq_flag_q)))
      else $error("service touched the done flag");

endmodule : data_eeprom_access_ctrl

// ==== verification/test_data_eeprom_access_ctrl.sv ====
/*
 * self-checking testbench for the data eeprom access controller: register
 * access through the special function register strobes, indirect control
 * access through both pointers, read and write cycles, interrupt flags.
 * sets short simulation counts on the design (2 ticks of 4 cycles).
 */
`timescale 1ns/1ps
module test_data_eeprom_access_ctrl;
   import nv_access_pkg::*;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic       mclk_i          = 1'b0;
   logic       rst_n_i         = 1'b0;
   logic [7:0] sfr_addr_i      = 8'h00;
   logic       sfr_wr_i        = 1'b0;
   logic [7:0] sfr_wdata_i     = 8'h00;
   logic       sfr_rd_i        = 1'b0;
   logic [7:0] sfr_rdata_o;
   logic       global_irq_on_i = 1'b0;
   logic       stack_full_i    = 1'b0;
   logic       irq_serviced_i  = 1'b0;
   logic       irq_vector_o;
   logic       nv_busy_o;
   int         err_count       = 0;
   int         comparisons     = 0;
   int         cycles          = 0;

   always #50 mclk_i = ~mclk_i;

   data_eeprom_access_ctrl #(
      .WRITE_TICKS(2),
      .TICK_DIV   (4)
   ) dut (
      .mclk_i         (mclk_i),
      .rst_n_i        (rst_n_i),
      .sfr_addr_i     (sfr_addr_i),
      .sfr_wr_i       (sfr_wr_i),
      .sfr_wdata_i    (sfr_wdata_i),
      .sfr_rd_i       (sfr_rd_i),
      .sfr_rdata_o    (sfr_rdata_o),
      .global_irq_on_i(global_irq_on_i),
      .stack_full_i   (stack_full_i),
      .irq_serviced_i (irq_serviced_i),
      .irq_vector_o   (irq_vector_o),
      .nv_busy_o      (nv_busy_o)
   );

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // strobes drop one edge later, so a following call never re-drives them in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      #1;
      sfr_addr_i  = a;
      sfr_wdata_i = d;
      sfr_wr_i    = 1'b1;
      @(posedge mclk_i);
      #1;
      sfr_wr_i = 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      #1;
      sfr_addr_i = a;
      sfr_rd_i   = 1'b1;
      @(posedge mclk_i);
      #1;
      sfr_rd_i = 1'b0;
      chk(sfr_rdata_o, exp);
   endtask : rd_chk

   task automatic wait_idle;
      for (int i = 0; i < 40 && nv_busy_o !== 1'b0; i++) begin
         @(posedge mclk_i);
         #1;
      end
      chk({7'h00, nv_busy_o}, 8'h00);
   endtask : wait_idle

   // ---------------------------------------------------------------
   // timeout: the sequence needs under two hundred cycles
   // ---------------------------------------------------------------
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(posedge mclk_i);
      #1;
      rst_n_i = 1'b1;
      rd_chk(PTR1_HI_ADDR, 8'h00);
      rd_chk(PTR2_HI_ADDR, 8'h00);
      wr(PTR1_LO_ADDR, CTRL_OFFSET);
      wr(IND1_ADDR, 8'h08);
      rd_chk(IND1_ADDR, 8'h00);
      wr(PTR1_HI_ADDR, CTRL_SECTOR);
      rd_chk(IND1_ADDR, 8'h00);
      wr(IND1_ADDR, 8'hf0);
      rd_chk(IND1_ADDR, 8'h00);
      wr(LOC_ADDR, 8'hff);
      rd_chk(LOC_ADDR, 8'h3f);
      wr(BYTE_ADDR, 8'h3c);
      rd_chk(BYTE_ADDR, 8'h3c);
      // go bits without permits must stay idle
      wr(IND1_ADDR, 8'h04);
      chk({7'h00, nv_busy_o}, 8'h00);
      rd_chk(IND1_ADDR, 8'h00);
      wr(IND1_ADDR, 8'h01);
      chk({7'h00, nv_busy_o}, 8'h00);
      rd_chk(IND1_ADDR, 8'h00);
      // write cycle to the top cell, interrupt enables on
      wr(IRQ_ADDR, 8'h05);
      wr(IND1_ADDR, 8'h08);
      wr(IND1_ADDR, 8'h0c);
      chk({7'h00, nv_busy_o}, 8'h01);
      rd_chk(IND1_ADDR, 8'h0c);
      wait_idle();
      rd_chk(IND1_ADDR, 8'h08);
      rd_chk(IRQ_ADDR, 8'h0f);
      @(posedge mclk_i);
      #1;
      global_irq_on_i = 1'b1;
      #1;
      chk({7'h00, irq_vector_o}, 8'h01);
      @(posedge mclk_i);
      #1;
      stack_full_i = 1'b1;
      #1;
      chk({7'h00, irq_vector_o}, 8'h00);
      @(posedge mclk_i);
      #1;
      stack_full_i   = 1'b0;
      irq_serviced_i = 1'b1;
      @(posedge mclk_i);
      #1;
      irq_serviced_i = 1'b0;
      chk({7'h00, irq_vector_o}, 8'h00);
      rd_chk(IRQ_ADDR, 8'h07);
      wr(IRQ_ADDR, 8'h05);
      rd_chk(IRQ_ADDR, 8'h05);
      // read cycle through pointer two, byte register cleared first
      wr(PTR2_LO_ADDR, CTRL_OFFSET);
      wr(PTR2_HI_ADDR, CTRL_SECTOR);
      wr(BYTE_ADDR, 8'h00);
      wr(IND2_ADDR, 8'h0a);
      wr(IND2_ADDR, 8'h0b);
      chk({7'h00, nv_busy_o}, 8'h01);
      wait_idle();
      rd_chk(IND2_ADDR, 8'h0a);
      rd_chk(BYTE_ADDR, 8'h3c);
      rd_chk(LOC_ADDR, 8'h3f);
      rd_chk(BYTE_ADDR, 8'h3c);
      // permit and go in one access: permit was not set before, so no write
      wr(IND2_ADDR, 8'h00);
      wr(BYTE_ADDR, 8'h77);
      wr(IND2_ADDR, 8'h0e);
      chk({7'h00, nv_busy_o}, 8'h00);
      wr(IND2_ADDR, 8'h0b);
      wait_idle();
      rd_chk(BYTE_ADDR, 8'h3c);
      // fetch permit dropped mid-read: go still clears, byte register kept
      wr(BYTE_ADDR, 8'h55);
      wr(IND2_ADDR, 8'h0b);
      wr(IND2_ADDR, 8'h08);
      chk({7'h00, nv_busy_o}, 8'h01);
      wait_idle();
      rd_chk(BYTE_ADDR, 8'h55);
      rd_chk(IND2_ADDR, 8'h08);
      rd_chk(IRQ_ADDR, 8'h05);
      tally_and_finish();
   end

endmodule : test_data_eeprom_access_ctrl
